/* verilog/csr_pkg.sv */
package csr_pkg;

  // register indices on the core's special-function bus
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LO = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HI = 8'h83;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_UART_CTRL = 8'h98;
  localparam logic [7:0] ADDR_UART_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
  localparam logic [7:0] ADDR_PORT3 = 8'hB0;
  localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'hB8;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_ACCUM = 8'hE0;
  localparam logic [7:0] ADDR_BREG = 8'hF0;
  // own registers: irq vector low byte and core state readback
  localparam logic [7:0] ADDR_IRQ_VECTOR = 8'hF8;
  localparam logic [7:0] ADDR_CORE_STATE = 8'hF9;

  // reset values
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field positions
  localparam int BANK_HI_BIT = 4;
  localparam int BANK_LO_BIT = 3;
  localparam int BAUD_DOUBLER_BIT = 7;
  localparam int POWER_DOWN_BIT = 1;
  localparam int SLEEP_REQ_BIT = 0;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int IT0_BIT = 0;
  localparam int IT1_BIT = 2;
  localparam int EXT0_FLAG_BIT = 1;
  localparam int EXT1_FLAG_BIT = 3;
  localparam int TF0_BIT = 5;
  localparam int TF1_BIT = 7;
  // implemented bit masks
  localparam logic [7:0] IRQ_ENABLE_MASK = 8'hBF;
  localparam logic [7:0] IRQ_PRIO_MASK = 8'h3F;
  localparam logic [7:0] POWER_CONTROL_MASK = 8'h8F;

  // interrupt vectors
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TIMER0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TIMER1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_TIMER2 = 16'h002B;
  localparam int NUM_SRC = 6;

  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_IDLE = 3'b010,
    PWR_DOWN = 3'b100
  } csr_pwr_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } csr_bus_s;

  typedef struct packed {
    logic valid;
    logic [15:0] vector;
    logic [2:0] source;
  } csr_irq_s;

  // bank base address from the two select bits
  function automatic logic [7:0] bank_base(input logic [1:0] sel);
    bank_base = {3'h0, sel, 3'h0};
  endfunction

endpackage

/* verilog/csr_irq_arb.sv */
`timescale 1ns/1ps
`default_nettype none
// fixed-priority interrupt selection with two levels
module csr_irq_arb
  import csr_pkg::*;
(
  input wire logic [NUM_SRC-1:0] req_i,
  input wire logic [7:0] enable_i,
  input wire logic [7:0] prio_i,
  output csr_irq_s irq_o
);
  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC-1:0] hi;
  logic [NUM_SRC-1:0] pick;
  logic [2:0] idx;
  logic [15:0] vec;

  // only enabled sources count, and none while global enable is low
  assign live = req_i & enable_i[NUM_SRC-1:0] &
                {NUM_SRC{enable_i[GLOBAL_EN_BIT]}};
  assign hi = live & prio_i[NUM_SRC-1:0];
  assign pick = (|hi) ? hi : live;

  // lowest index wins inside a level
  always_comb begin
    idx = 3'd0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        idx = 3'(i);
      end
    end
  end

  // fixed vector table
  always_comb begin
    case (idx)
      3'd0: vec = VEC_EXT0;
      3'd1: vec = VEC_TIMER0;
      3'd2: vec = VEC_EXT1;
      3'd3: vec = VEC_TIMER1;
      3'd4: vec = VEC_UART;
      3'd5: vec = VEC_TIMER2;
      default: vec = VEC_EXT0;
    endcase
  end

  assign irq_o = '{valid: |live, vector: vec, source: idx};
endmodule // csr_irq_arb
`default_nettype wire

/* verilog/csr_core_regs.sv */
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs
  import csr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic ext0_n_i,
  input wire logic ext1_n_i,
  input wire logic [3:0] irq_src_i,
  input wire logic irq_ack_i,
  input wire logic wake_i,
  input wire logic timer1_baud_i,
  input wire logic [1:0] uart_mode_i,
  output logic [7:0] rdata_o,
  output logic [7:0] bank_base_o,
  output logic baud_double_o,
  output logic idle_o,
  output logic power_down_o,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o
);
  csr_bus_s bus;
  csr_irq_s sel;
  csr_pwr_e pwr_r, pwr_nxt;
  logic [7:0] acc_r, breg_r, psw_r, sp_r, dpl_r, dph_r, power_control_r;
  logic [7:0] ien_r, ipr_r, tcon_r, tmod_r, scon_r, ubuf_r;
  logic [7:0] port_r [4];
  logic [7:0] rdata_r, bank_r;
  logic [15:0] vec_r;
  logic baud_r, irq_r, ext0_d_r, ext1_d_r;
  logic [7:0] rd_mux;
  logic ext0_fall, ext1_fall, ext0_lvl, ext1_lvl;
  logic [NUM_SRC-1:0] req;
  logic w_power_control, ack0, ack1;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign w_power_control = bus.wr && bus.addr == ADDR_POWER_CONTROL;

  // register writes; reset holds until first write
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_r <= RST_ZERO;
      breg_r <= RST_ZERO;
      psw_r <= RST_ZERO;
      sp_r <= RST_STACK_POINTER;
      dpl_r <= RST_ZERO;
      dph_r <= RST_ZERO;
      tmod_r <= RST_ZERO;
      scon_r <= RST_ZERO;
      ien_r <= RST_ZERO;
      ipr_r <= RST_ZERO;
      power_control_r <= RST_ZERO;
      for (int i = 0; i < 4; i++) begin
        port_r[i] <= RST_PORT;
      end
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_ACCUM: acc_r <= bus.wdata;
        ADDR_BREG: breg_r <= bus.wdata;
        ADDR_STATUS_WORD: psw_r <= bus.wdata;
        ADDR_STACK_POINTER: sp_r <= bus.wdata;
        ADDR_DATA_POINTER_LO: dpl_r <= bus.wdata;
        ADDR_DATA_POINTER_HI: dph_r <= bus.wdata;
        ADDR_TIMER_MODE: tmod_r <= bus.wdata;
        ADDR_UART_CTRL: scon_r <= bus.wdata;
        ADDR_IRQ_ENABLE: ien_r <= bus.wdata & IRQ_ENABLE_MASK;
        ADDR_IRQ_PRIORITY: ipr_r <= bus.wdata & IRQ_PRIO_MASK;
        ADDR_POWER_CONTROL: power_control_r <= bus.wdata & POWER_CONTROL_MASK;
        ADDR_PORT0: port_r[0] <= bus.wdata;
        ADDR_PORT1: port_r[1] <= bus.wdata;
        ADDR_PORT2: port_r[2] <= bus.wdata;
        ADDR_PORT3: port_r[3] <= bus.wdata;
        default: ;
      endcase
    end
  end

  // uart buffer has no reset value
  always_ff @(posedge core_clk_i) begin
    if (bus.wr && bus.addr == ADDR_UART_BUFFER) begin
      ubuf_r <= bus.wdata;
    end
  end

  // external pin edge/level detection
  assign ext0_fall = ext0_d_r & ~ext0_n_i;
  assign ext1_fall = ext1_d_r & ~ext1_n_i;
  assign ext0_lvl = ~ext0_n_i;
  assign ext1_lvl = ~ext1_n_i;
  assign ack0 = irq_ack_i && sel.valid && sel.source == 3'd0;
  assign ack1 = irq_ack_i && sel.valid && sel.source == 3'd2;

  // timer control; edge flags set wins over hardware ack and write
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tcon_r <= RST_ZERO;
      ext0_d_r <= 1'b1;
      ext1_d_r <= 1'b1;
    end else begin
      ext0_d_r <= ext0_n_i;
      ext1_d_r <= ext1_n_i;
      if (bus.wr && bus.addr == ADDR_TIMER_CTRL) begin
        tcon_r <= bus.wdata;
      end else begin
        if (ack0) tcon_r[EXT0_FLAG_BIT] <= 1'b0;
        if (ack1) tcon_r[EXT1_FLAG_BIT] <= 1'b0;
      end
      if (tcon_r[IT0_BIT] && ext0_fall) tcon_r[EXT0_FLAG_BIT] <= 1'b1;
      if (tcon_r[IT1_BIT] && ext1_fall) tcon_r[EXT1_FLAG_BIT] <= 1'b1;
    end
  end

  // request vector: level or latched edge per type bit
  assign req[0] = tcon_r[IT0_BIT] ? tcon_r[EXT0_FLAG_BIT]
                                  : ext0_lvl;
  assign req[1] = tcon_r[TF0_BIT];
  assign req[2] = tcon_r[IT1_BIT] ? tcon_r[EXT1_FLAG_BIT]
                                  : ext1_lvl;
  assign req[3] = tcon_r[TF1_BIT];
  // uart rx/tx share one source, timer 2 overflow/external the next
  assign req[4] = irq_src_i[0] | irq_src_i[1];
  assign req[5] = irq_src_i[2] | irq_src_i[3];

  csr_irq_arb u_arb (
    .req_i(req),
    .enable_i(ien_r),
    .prio_i(ipr_r),
    .irq_o(sel)
  );

  // power state: power-down beats idle
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_RUN: begin
        if (w_power_control && bus.wdata[POWER_DOWN_BIT]) begin
          pwr_nxt = PWR_DOWN;
        end else if (w_power_control && bus.wdata[SLEEP_REQ_BIT]) begin
          pwr_nxt = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (wake_i || sel.valid) pwr_nxt = PWR_RUN;
      end
      PWR_DOWN: begin
        if (wake_i) pwr_nxt = PWR_RUN;
      end
      default: pwr_nxt = PWR_RUN;
    endcase
  end

  // read mux
  always_comb begin
    case (bus.addr)
      ADDR_ACCUM: rd_mux = acc_r;
      ADDR_BREG: rd_mux = breg_r;
      ADDR_STATUS_WORD: rd_mux = psw_r;
      ADDR_STACK_POINTER: rd_mux = sp_r;
      ADDR_DATA_POINTER_LO: rd_mux = dpl_r;
      ADDR_DATA_POINTER_HI: rd_mux = dph_r;
      ADDR_TIMER_MODE: rd_mux = tmod_r;
      ADDR_TIMER_CTRL: rd_mux = tcon_r;
      ADDR_UART_CTRL: rd_mux = scon_r;
      ADDR_UART_BUFFER: rd_mux = ubuf_r;
      ADDR_IRQ_ENABLE: rd_mux = ien_r;
      ADDR_IRQ_PRIORITY: rd_mux = ipr_r;
      ADDR_POWER_CONTROL: rd_mux = power_control_r;
      ADDR_PORT0: rd_mux = port_r[0];
      ADDR_PORT1: rd_mux = port_r[1];
      ADDR_PORT2: rd_mux = port_r[2];
      ADDR_PORT3: rd_mux = port_r[3];
      ADDR_IRQ_VECTOR: rd_mux = vec_r[7:0];
      ADDR_CORE_STATE: rd_mux = {5'h00, pwr_r};
      default: rd_mux = RST_ZERO;
    endcase
  end

  // registered outputs
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_r <= PWR_RUN;
      rdata_r <= RST_ZERO;
      bank_r <= RST_ZERO;
      baud_r <= 1'b0;
      irq_r <= 1'b0;
      vec_r <= VEC_EXT0;
    end else begin
      pwr_r <= pwr_nxt;
      rdata_r <= bus.rd ? rd_mux : RST_ZERO;
      bank_r <= bank_base(psw_r[BANK_HI_BIT:BANK_LO_BIT]);
      baud_r <= power_control_r[BAUD_DOUBLER_BIT] & timer1_baud_i &
                (uart_mode_i != 2'd0);
      irq_r <= sel.valid;
      vec_r <= sel.vector;
    end
  end

  assign rdata_o = rdata_r;
  assign bank_base_o = bank_r;
  assign baud_double_o = baud_r;
  assign idle_o = pwr_r[1]; // one-hot idle bit
  assign power_down_o = pwr_r[2]; // one-hot power-down bit
  assign irq_req_o = irq_r;
  assign irq_vector_o = vec_r;

  // checks
  sp_reset_a: assert property (@(posedge core_clk_i)
    $fell(reset_i) |-> sp_r == RST_STACK_POINTER && port_r[3] == RST_PORT)
    else $error("stack pointer or port not at reset value");
  bank_map_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 bank_r == {3'h0, $past(psw_r[4:3]), 3'h0})
    else $error("bank base mismatch");
  pd_wins_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pwr_r == PWR_RUN && w_power_control && bus.wdata[1:0] == 2'b11
    |=> pwr_r == PWR_DOWN)
    else $error("power-down did not take precedence");
  idle_entry_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pwr_r == PWR_RUN && w_power_control && bus.wdata[1:0] == 2'b01
    |=> pwr_r == PWR_IDLE)
    else $error("idle not entered");
  pd_entry_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pwr_r == PWR_RUN && w_power_control && bus.wdata[1] |=> power_down_o)
    else $error("power-down not entered");
  global_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !ien_r[7] |=> !irq_req_o)
    else $error("irq raised with global enable low");
  src_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    sel.valid |-> ien_r[7] && ien_r[sel.source])
    else $error("disabled source selected");
  vec_map_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    sel.valid |=> vec_r == {10'h000, $past(sel.source), 3'h3})
    else $error("vector address wrong");
  baud_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    power_control_r[7] && timer1_baud_i && uart_mode_i == 2'd0 |=> !baud_r)
    else $error("baud doubled in mode 0");
  edge_latch_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    tcon_r[0] && ext0_fall |=> tcon_r[1])
    else $error("edge flag not latched");
  cv_pd: cover property (@(posedge core_clk_i) pwr_r == PWR_DOWN);
  cv_idle: cover property (@(posedge core_clk_i) pwr_r == PWR_IDLE);
  cv_irq: cover property (@(posedge core_clk_i) irq_req_o && vec_r == VEC_UART);
endmodule // csr_core_regs
`default_nettype wire

/* tb/csr_core_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_tb
  import csr_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, ack = 1'b0, wake = 1'b0, t1_baud = 1'b0;
  logic ext0_n = 1'b1, ext1_n = 1'b1;
  logic [3:0] irq_src = 4'h0;
  logic [1:0] uart_mode = 2'h0;
  logic [7:0] rdata, bank_base, rv;
  logic baud_double, idle, power_down, irq_req;
  logic [15:0] irq_vector;
  int failures = 0;
  int check_count = 0;
  int seed = 45;
  int cycles = 0;
  logic [7:0] rnd;
  localparam logic [7:0] RST_LIST [17] = '{8'h81, 8'h80, 8'h90, 8'hA0,
    8'hB0, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h98, 8'hA8, 8'hB8,
    8'hD0, 8'hE0, 8'hF0, 8'h8F};

  csr_core_regs dut_u (.core_clk_i(core_clk), .reset_i(reset),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .ext0_n_i(ext0_n), .ext1_n_i(ext1_n), .irq_src_i(irq_src),
    .irq_ack_i(ack), .wake_i(wake), .timer1_baud_i(t1_baud),
    .uart_mode_i(uart_mode), .rdata_o(rdata), .bank_base_o(bank_base),
    .baud_double_o(baud_double), .idle_o(idle),
    .power_down_o(power_down), .irq_req_o(irq_req),
    .irq_vector_o(irq_vector));

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      $display("ERROR %0t timeout", $time);
      conclude();
    end
  end

  // expected values
  function automatic logic [7:0] exp_rst(input logic [7:0] a);
    case (a)
      8'h81: exp_rst = 8'h07;
      8'h80, 8'h90, 8'hA0, 8'hB0: exp_rst = 8'hFF;
      default: exp_rst = 8'h00;
    endcase
  endfunction
  function automatic logic [15:0] exp_vec(input int idx);
    case (idx)
      0: exp_vec = 16'h0003;
      1: exp_vec = 16'h000B;
      2: exp_vec = 16'h0013;
      3: exp_vec = 16'h001B;
      4: exp_vec = 16'h0023;
      default: exp_vec = 16'h002B;
    endcase
  endfunction

  // comparisons
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t vector got %h exp %h", $time, got, exp);
    end
  endtask

  // register bus cycles
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic check_resets();
    for (int i = 0; i < 17; i++) begin
      reg_rd(RST_LIST[i], rv);
      chk_byte(rv, exp_rst(RST_LIST[i]));
    end
    chk_byte(bank_base, 8'h00);
    chk_vec(irq_vector, 16'h0003);
  endtask
  // one source under a given enable pattern
  task automatic irq_case(input int idx, input logic [7:0] en,
                          input logic exp);
    reg_wr(8'hA8, en);
    rnd = $random(seed);
    @(posedge core_clk);
    case (idx)
      0: ext0_n <= 1'b0;
      1: reg_wr(8'h88, 8'h20);
      2: ext1_n <= 1'b0;
      3: reg_wr(8'h88, 8'h80);
      4: irq_src <= rnd[0] ? 4'h1 : 4'h2;
      default: irq_src <= rnd[0] ? 4'h4 : 4'h8;
    endcase
    settle();
    chk_bit(irq_req, exp);
    if (exp) chk_vec(irq_vector, exp_vec(idx));
    @(posedge core_clk);
    ext0_n <= 1'b1;
    ext1_n <= 1'b1;
    irq_src <= 4'h0;
    reg_wr(8'h88, 8'h00);
    settle();
    chk_bit(irq_req, 1'b0);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    check_resets();
    $display("test reset values done");
    // bank select, random data stores, unmapped place
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      reg_wr(8'hD0, rnd);
      settle();
      chk_byte(bank_base, {3'h0, rnd[4:3], 3'h0});
      reg_wr((i % 2) ? 8'hE0 : 8'hF0, rnd);
      reg_rd((i % 2) ? 8'hE0 : 8'hF0, rv);
      chk_byte(rv, rnd);
      reg_wr(8'h8F, rnd);
      reg_rd(8'h8F, rv);
      chk_byte(rv, 8'h00);
    end
    $display("test bank and data done");
    // baud doubling over every mode and source
    for (int i = 0; i < 16; i++) begin
      reg_wr(8'h87, {i[3], 7'h00});
      t1_baud <= i[2];
      uart_mode <= i[1:0];
      settle();
      chk_bit(baud_double, i[3] & i[2] & (i[1:0] != 2'h0));
    end
    reg_wr(8'h87, 8'h00);
    $display("test baud done");
    // power requests, both at once last
    for (int i = 1; i < 4; i++) begin
      reg_wr(8'h87, i[7:0]);
      settle();
      chk_bit(power_down, i[1]);
      chk_bit(idle, i[0] & ~i[1]);
      @(posedge core_clk);
      wake <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
      settle();
      chk_bit(power_down | idle, 1'b0);
    end
    $display("test power done");
    reg_wr(8'hB0, 8'hFF);
    // each source: own bit off, global off, both on
    for (int i = 0; i < 6; i++) begin
      irq_case(i, 8'hBF ^ (8'h01 << i), 1'b0);
      irq_case(i, 8'h3F, 1'b0);
      irq_case(i, 8'h80 | (8'h01 << i), 1'b1);
    end
    // priority level beats fixed order
    reg_wr(8'hA8, 8'h89);
    reg_wr(8'hB8, 8'h08);
    reg_wr(8'h88, 8'h80);
    @(posedge core_clk);
    ext0_n <= 1'b0;
    settle();
    chk_vec(irq_vector, 16'h001B);
    reg_wr(8'hB8, 8'h00);
    settle();
    chk_vec(irq_vector, 16'h0003);
    @(posedge core_clk);
    ext0_n <= 1'b1;
    reg_wr(8'h88, 8'h00);
    settle();
    // external 0 by transition: flag survives pin release
    reg_wr(8'hA8, 8'h81);
    reg_wr(8'h88, 8'h01);
    @(posedge core_clk);
    ext0_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    ext0_n <= 1'b1;
    settle();
    chk_bit(irq_req, 1'b1);
    chk_vec(irq_vector, 16'h0003);
    @(posedge core_clk);
    ack <= 1'b1;
    @(posedge core_clk);
    ack <= 1'b0;
    settle();
    chk_bit(irq_req, 1'b0);
    $display("test interrupts done");
    // second reset in mid-run
    reg_wr(8'hE0, 8'h5A);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    check_resets();
    $display("test second reset done");
    conclude();
  end
endmodule // csr_core_regs_tb
`default_nettype wire
